// [hw/acr_regs.sv]
// Functional notes
// - 7-bit address selects register accessed
// - Identification register returns fixed code only
// - Rate bit: 0 is 100 Hz, 1 is 400 Hz
// - Power bit: 0 power-down, 1 active
// - Range select bit, resets to 0
// - Self-test bits enable stimulus, default off
// - Axis enables gate data-ready, default on
// - Wire mode: 0 four-wire, 1 three-wire
// - Reload bit copies trim, then self-clears
// - Trim copied automatically at power-up
// - Filtered output select, default bypass
// - Filter to each detector, default bypass
// - Cut-off field sets corner frequency
// - Interrupt polarity: 0 high, 1 low
// - Interrupt drive: 0 push-pull, 1 open-drain
// - Each pad has 3-bit source select
// - Reading clear address zeroes filter state
`include "acr_map.svh"
`timescale 1ns/1ps
`default_nettype none
module acr_regs
   import acr_pkg::*;
#(
   parameter logic [7:0]  PART_ID   = 8'ha5, // Arbitrary value
   parameter int          SLOW_DIV  = `ACR_SLOW_DIV,
   parameter int          FAST_DIV  = `ACR_FAST_DIV,
   parameter int          TRIM_WORDS = `ACR_TRIM_WORDS,
   parameter logic [TRIM_WORDS*8-1:0] TRIM_INIT = 32'h5a3c_9612
)
(
   // Clock and reset
   input  wire logic                    i_clk,
   input  wire logic                    i_rst,
   // Register access from serial front end
   input  wire logic [6:0]              i_reg_addr,
   input  wire logic                    i_reg_wr,
   input  wire logic [7:0]              i_reg_wdata,
   input  wire logic                    i_reg_rd,
   output var  logic [7:0]              o_reg_rdata,
   output var  logic                    o_reg_rvalid,
   // Measurement control
   output var  logic                    o_sample_rate_select,
   output var  logic                    o_active_mode_control,
   output var  logic                    o_range_select,
   output var  logic                    o_self_test_plus,
   output var  logic                    o_self_test_minus,
   output var  logic [2:0]              o_axis_enable,
   output var  logic                    o_sample_tick,
   output var  logic [2:0]              o_axis_data_ready,
   // Interface and filter control
   output var  logic                    o_wire_mode_select,
   output var  logic                    o_filtered_output_select,
   output var  logic                    o_filter_to_detector_one,
   output var  logic                    o_filter_to_detector_two,
   output var  logic [1:0]              o_cutoff_select,
   output var  logic [5:0]              o_cutoff_quarter_hz,
   output var  logic                    o_filter_clear,
   // Trim
   output var  logic                    o_boot_busy,
   output var  logic [TRIM_WORDS*8-1:0] o_trim,
   // Interrupt sources
   input  wire logic                    i_motion_detector_one,
   input  wire logic                    i_motion_detector_two,
   input  wire logic                    i_data_ready,
   input  wire logic                    i_click,
   // Interrupt pads
   output var  logic                    o_irq_pad_one,
   output var  logic                    o_irq_pad_one_oe,
   output var  logic                    o_irq_pad_two,
   output var  logic                    o_irq_pad_two_oe
);
   localparam int TRIM_AW = (TRIM_WORDS > 1) ? $clog2(TRIM_WORDS) : 1;
   localparam int DIV_W   = $clog2(SLOW_DIV + 1);
   localparam logic [DIV_W-1:0] SLOW_LAST = DIV_W'(SLOW_DIV - 1);
   localparam logic [DIV_W-1:0] FAST_LAST = DIV_W'(FAST_DIV - 1);
   localparam logic [TRIM_AW-1:0] TRIM_LAST = TRIM_AW'(TRIM_WORDS - 1);

   // Corner frequency in quarter hertz
   function automatic logic [5:0] cutoff_qhz(input logic fast, input logic [1:0] code);
      logic [5:0] base;
      base = fast ? `ACR_CUT_BASE_FAST : `ACR_CUT_BASE_SLOW;
      return base >> code;
   endfunction

   // Pad level before polarity
   function automatic logic pad_source(input logic [2:0] sel, input logic d1, input logic d2,
                                       input logic drdy, input logic clk_irq);
      logic v;
      v = 1'b0;
      case (sel)
         `ACR_SRC_DET1:   v = d1;
         `ACR_SRC_DET2:   v = d2;
         `ACR_SRC_DET_OR: v = d1 | d2;
         `ACR_SRC_DRDY:   v = drdy;
         `ACR_SRC_CLICK:  v = clk_irq;
         default:         v = 1'b0;
      endcase
      return v;
   endfunction

   acr_byte_t                rate_power_axis_control;
   acr_byte_t                interface_filter_control;
   acr_byte_t                interrupt_pad_control;
   acr_boot_t                boot_state;
   logic [TRIM_AW-1:0]       trim_idx;
   logic [7:0]               trim_rd_data;
   logic [DIV_W-1:0]         div_cnt;

   // Address decode
   wire sel_id    = (i_reg_addr == `ACR_ADDR_PART_ID);
   wire sel_rate  = (i_reg_addr == `ACR_ADDR_RATE_CTRL);
   wire sel_iface = (i_reg_addr == `ACR_ADDR_IFACE_CTRL);
   wire sel_irq   = (i_reg_addr == `ACR_ADDR_IRQ_CTRL);
   wire sel_clear = (i_reg_addr == `ACR_ADDR_FILT_CLEAR);

   wire wr_rate   = i_reg_wr & sel_rate;
   wire wr_iface  = i_reg_wr & sel_iface;
   wire wr_irq    = i_reg_wr & sel_irq;
   wire reload_req = wr_iface & i_reg_wdata[`ACR_B_RELOAD];
   wire boot_run  = (boot_state != ACR_BOOT_IDLE);

   // Fixed bit and reload bit are stored but masked on read; fixed reads 0, reload reads back as busy
   wire [7:0] iface_view = {interface_filter_control[7],
                            boot_run,
                            1'b0,
                            interface_filter_control[4:0]};

   wire [7:0] next_rdata = sel_id    ? PART_ID :
                           sel_rate  ? rate_power_axis_control :
                           sel_iface ? iface_view :
                           sel_irq   ? interrupt_pad_control :
                           8'h00;

   wire fast_rate = rate_power_axis_control[`ACR_B_RATE];
   wire active    = rate_power_axis_control[`ACR_B_ACTIVE];
   wire [DIV_W-1:0] div_last = fast_rate ? FAST_LAST : SLOW_LAST;
   wire div_wrap  = (div_cnt >= div_last);

   wire irq_pol   = interrupt_pad_control[`ACR_B_IRQ_POL];
   wire irq_od    = interrupt_pad_control[`ACR_B_IRQ_DRIVE];
   wire lvl_one   = pad_source(interrupt_pad_control[`ACR_F_PAD1_SRC], i_motion_detector_one,
                               i_motion_detector_two, i_data_ready, i_click);
   wire lvl_two   = pad_source(interrupt_pad_control[`ACR_F_PAD2_SRC], i_motion_detector_one,
                               i_motion_detector_two, i_data_ready, i_click);
   wire pin_one   = lvl_one ^ irq_pol;
   wire pin_two   = lvl_two ^ irq_pol;
   // Open drain only pulls low
   wire oe_one    = irq_od ? ~pin_one : 1'b1;
   wire oe_two    = irq_od ? ~pin_two : 1'b1;

   // Control registers
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
      begin
         rate_power_axis_control  <= `ACR_RST_RATE_CTRL;
         interface_filter_control <= `ACR_RST_IFACE_CTRL;
         interrupt_pad_control    <= `ACR_RST_IRQ_CTRL;
      end
      else
      begin
         if (wr_rate)
         begin
            rate_power_axis_control <= i_reg_wdata;
         end
         if (wr_iface)
         begin
            interface_filter_control <= i_reg_wdata;
         end
         if (wr_irq)
         begin
            interrupt_pad_control <= i_reg_wdata;
         end
      end
   end

   // Read port
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
      begin
         o_reg_rdata    <= 8'h00;
         o_reg_rvalid   <= 1'b0;
         o_filter_clear <= 1'b0;
      end
      else
      begin
         o_reg_rvalid   <= i_reg_rd;
         o_reg_rdata    <= i_reg_rd ? next_rdata : o_reg_rdata;
         o_filter_clear <= i_reg_rd & sel_clear;
      end
   end

   // Trim copy: power-up and on request, a new request restarts it
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
      begin
         boot_state <= ACR_BOOT_ADDR;
         trim_idx   <= '0;
      end
      else if (reload_req)
      begin
         boot_state <= ACR_BOOT_ADDR;
         trim_idx   <= '0;
      end
      else
      begin
         unique case (boot_state)
            ACR_BOOT_IDLE:
            begin
               boot_state <= ACR_BOOT_IDLE;
            end
            ACR_BOOT_ADDR:
            begin
               boot_state <= ACR_BOOT_STORE;
            end
            ACR_BOOT_STORE:
            begin
               if (trim_idx == TRIM_LAST)
               begin
                  boot_state <= ACR_BOOT_IDLE;
               end
               else
               begin
                  boot_state <= ACR_BOOT_ADDR;
                  trim_idx   <= trim_idx + 1'b1;
               end
            end
         endcase
      end
   end

   always_ff @(posedge i_clk)
   begin
      if (i_rst)
      begin
         o_trim <= '0;
      end
      else if (boot_state == ACR_BOOT_STORE)
      begin
         o_trim[trim_idx*8 +: 8] <= trim_rd_data;
      end
   end

   acr_trim_mem #(
      .WORDS  (TRIM_WORDS),
      .ADDR_W (TRIM_AW),
      .INIT   (TRIM_INIT)
   ) u_trim_mem (
      .i_clk     (i_clk),
      .i_rd_en   (boot_state == ACR_BOOT_ADDR),
      .i_rd_addr (trim_idx),
      .o_rd_data (trim_rd_data)
   );

   // Sample rate divider, cleared while powered down
   always_ff @(posedge i_clk)
   begin
      if (i_rst || !active)
      begin
         div_cnt           <= '0;
         o_sample_tick     <= 1'b0;
         o_axis_data_ready <= 3'h0;
      end
      else
      begin
         div_cnt           <= div_wrap ? '0 : div_cnt + 1'b1;
         o_sample_tick     <= div_wrap;
         o_axis_data_ready <= {3{div_wrap}} & rate_power_axis_control[`ACR_F_AXIS];
      end
   end

   // Registered copies of control fields
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
      begin
         o_sample_rate_select     <= 1'b0;
         o_active_mode_control    <= 1'b0;
         o_range_select           <= 1'b0;
         o_self_test_plus         <= 1'b0;
         o_self_test_minus        <= 1'b0;
         o_axis_enable            <= 3'h7;
         o_wire_mode_select       <= 1'b0;
         o_filtered_output_select <= 1'b0;
         o_filter_to_detector_one <= 1'b0;
         o_filter_to_detector_two <= 1'b0;
         o_cutoff_select          <= 2'h0;
         o_cutoff_quarter_hz      <= `ACR_CUT_BASE_SLOW;
         o_boot_busy              <= 1'b1;
      end
      else
      begin
         o_sample_rate_select     <= fast_rate;
         o_active_mode_control    <= active;
         o_range_select           <= rate_power_axis_control[`ACR_B_RANGE];
         o_self_test_plus         <= rate_power_axis_control[`ACR_B_ST_PLUS];
         o_self_test_minus        <= rate_power_axis_control[`ACR_B_ST_MINUS];
         o_axis_enable            <= rate_power_axis_control[`ACR_F_AXIS];
         o_wire_mode_select       <= interface_filter_control[`ACR_B_WIRE];
         o_filtered_output_select <= interface_filter_control[`ACR_B_FILT_OUT];
         o_filter_to_detector_one <= interface_filter_control[`ACR_B_FILT_DET1];
         o_filter_to_detector_two <= interface_filter_control[`ACR_B_FILT_DET2];
         o_cutoff_select          <= interface_filter_control[`ACR_F_CUTOFF];
         o_cutoff_quarter_hz      <= cutoff_qhz(fast_rate,
                                                interface_filter_control[`ACR_F_CUTOFF]);
         o_boot_busy              <= boot_run;
      end
   end

   // Interrupt pads
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
      begin
         o_irq_pad_one    <= 1'b0;
         o_irq_pad_one_oe <= 1'b1;
         o_irq_pad_two    <= 1'b0;
         o_irq_pad_two_oe <= 1'b1;
      end
      else
      begin
         o_irq_pad_one    <= irq_od ? 1'b0 : pin_one;
         o_irq_pad_one_oe <= oe_one;
         o_irq_pad_two    <= irq_od ? 1'b0 : pin_two;
         o_irq_pad_two_oe <= oe_two;
      end
   end
endmodule
`default_nettype wire

// [hw/acr_map.svh]
`ifndef ACR_MAP_SVH
`define ACR_MAP_SVH

// Register addresses (7-bit)
`define ACR_ADDR_PART_ID      7'h0f
`define ACR_ADDR_RATE_CTRL    7'h20
`define ACR_ADDR_IFACE_CTRL   7'h21
`define ACR_ADDR_IRQ_CTRL     7'h22
`define ACR_ADDR_FILT_CLEAR   7'h23

// Reset values
`define ACR_RST_RATE_CTRL     8'h07
`define ACR_RST_IFACE_CTRL    8'h00
`define ACR_RST_IRQ_CTRL      8'h00

// rate_power_axis_control fields
`define ACR_B_RATE            7
`define ACR_B_ACTIVE          6
`define ACR_B_RANGE           5
`define ACR_B_ST_PLUS         4
`define ACR_B_ST_MINUS        3
`define ACR_F_AXIS            2:0

// interface_filter_control fields
`define ACR_B_WIRE            7
`define ACR_B_RELOAD          6
`define ACR_B_FIXED_ZERO      5
`define ACR_B_FILT_OUT        4
`define ACR_B_FILT_DET2       3
`define ACR_B_FILT_DET1       2
`define ACR_F_CUTOFF          1:0

// interrupt_pad_control fields
`define ACR_B_IRQ_POL         7
`define ACR_B_IRQ_DRIVE       6
`define ACR_F_PAD2_SRC        5:3
`define ACR_F_PAD1_SRC        2:0

// Pad source codes
`define ACR_SRC_GND           3'h0
`define ACR_SRC_DET1          3'h1
`define ACR_SRC_DET2          3'h2
`define ACR_SRC_DET_OR        3'h3
`define ACR_SRC_DRDY          3'h4
`define ACR_SRC_CLICK         3'h7

// Timing
`define ACR_CLK_HZ            40000000
`define ACR_SLOW_RATE_HZ      100
`define ACR_FAST_RATE_HZ      400
`define ACR_SLOW_DIV          (`ACR_CLK_HZ / `ACR_SLOW_RATE_HZ)
`define ACR_FAST_DIV          (`ACR_CLK_HZ / `ACR_FAST_RATE_HZ)

// Cut-off in quarter hertz at code 00
`define ACR_CUT_BASE_SLOW     6'h08
`define ACR_CUT_BASE_FAST     6'h20

// Trim storage
`define ACR_TRIM_WORDS        4

`endif

// [hw/acr_pkg.sv]
package acr_pkg;
   typedef logic [6:0] acr_addr_t;
   typedef logic [7:0] acr_byte_t;
   typedef enum logic [1:0] {
      ACR_BOOT_IDLE,
      ACR_BOOT_ADDR,
      ACR_BOOT_STORE
   } acr_boot_t;
endpackage

// [hw/acr_trim_mem.sv]
`timescale 1ns/1ps
`default_nettype none
module acr_trim_mem
#(
   parameter int               WORDS  = 4,
   parameter int               ADDR_W = 2,
   parameter logic [WORDS*8-1:0] INIT = '0
)
(
   // Clock
   input  wire logic              i_clk,
   // Read port
   input  wire logic              i_rd_en,
   input  wire logic [ADDR_W-1:0] i_rd_addr,
   output var  logic [7:0]        o_rd_data
);
   logic [7:0] store [WORDS];

   // Factory contents, never written at run time
   always_comb
   begin
      for (int k = 0; k < WORDS; k++)
      begin
         store[k] = INIT[k*8 +: 8];
      end
   end

   always_ff @(posedge i_clk)
   begin
      if (i_rd_en)
      begin
         o_rd_data <= store[i_rd_addr];
      end
   end
endmodule
`default_nettype wire

// [tb/acr_regs_properties.sv]
`timescale 1ns/1ps
`default_nettype none
module acr_regs_properties
#(
   parameter logic [7:0]              PART_ID    = 8'ha5,
   parameter int                      TRIM_WORDS = 4,
   parameter logic [TRIM_WORDS*8-1:0] TRIM_INIT  = '0
)
(
   // Clock, reset and register port
   input wire logic       i_clk,
   input wire logic       i_rst,
   input wire logic [6:0] i_reg_addr,
   input wire logic       i_reg_wr,
   input wire logic [7:0] i_reg_wdata,
   input wire logic       i_reg_rd,
   input wire logic [7:0] o_reg_rdata,
   input wire logic       o_reg_rvalid,
   // Control copies
   input wire logic       o_sample_rate_select,
   input wire logic       o_active_mode_control,
   input wire logic       o_range_select,
   input wire logic       o_self_test_plus,
   input wire logic       o_self_test_minus,
   input wire logic [2:0] o_axis_enable,
   input wire logic       o_sample_tick,
   input wire logic [2:0] o_axis_data_ready,
   input wire logic       o_wire_mode_select,
   input wire logic       o_filtered_output_select,
   input wire logic       o_filter_to_detector_one,
   input wire logic       o_filter_to_detector_two,
   input wire logic [1:0] o_cutoff_select,
   input wire logic [5:0] o_cutoff_quarter_hz,
   input wire logic       o_filter_clear,
   // Trim
   input wire logic       o_boot_busy,
   input wire logic [TRIM_WORDS*8-1:0] o_trim,
   // Interrupts
   input wire logic       i_motion_detector_one,
   input wire logic       i_motion_detector_two,
   input wire logic       i_data_ready,
   input wire logic       i_click,
   input wire logic       o_irq_pad_one,
   input wire logic       o_irq_pad_one_oe,
   input wire logic       o_irq_pad_two,
   input wire logic       o_irq_pad_two_oe
);
   logic [7:0] irq_cfg;
   logic [3:0] srcs;
   logic [1:0] want_one;
   logic [1:0] want_two;

   // Expected pad value and enable for one source code
   function automatic logic [1:0] pad_of(input logic [2:0] c, input logic [7:0] cfg, input logic [3:0] s);
      logic l;
      l = cfg[7] ^ (c == 3'h1 ? s[0] : c == 3'h2 ? s[1] : c == 3'h3 ? |s[1:0] :
                    c == 3'h4 ? s[2] : c == 3'h7 ? s[3] : 1'b0);
      return cfg[6] ? {1'b0, ~l} : {l, 1'b1};
   endfunction

   assign srcs     = {i_click, i_data_ready, i_motion_detector_two, i_motion_detector_one};
   assign want_one = pad_of(irq_cfg[2:0], irq_cfg, srcs);
   assign want_two = pad_of(irq_cfg[5:3], irq_cfg, srcs);

   always_ff @(posedge i_clk)
   begin
      if (i_rst)
         irq_cfg <= 8'h00;
      else if (i_reg_wr && i_reg_addr == 7'h22)
         irq_cfg <= i_reg_wdata;
   end

   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (i_rst);

   rvalid_pulse_a: assert property (o_reg_rvalid == $past(i_reg_rd)) else $error("rvalid");
   part_id_a: assert property (i_reg_rd && i_reg_addr == 7'h0f |=> o_reg_rdata == PART_ID) else $error("id");
   unmapped_zero_a: assert property (i_reg_rd && !(i_reg_addr inside {7'h0f, 7'h20, 7'h21, 7'h22})
      |=> o_reg_rdata == 8'h00) else $error("unmapped");
   clear_pulse_a: assert property (o_filter_clear == ($past(i_reg_rd) && $past(i_reg_addr) == 7'h23))
      else $error("clear");
   rate_copy_a: assert property (i_reg_wr && i_reg_addr == 7'h20 |-> ##2
      {o_sample_rate_select, o_active_mode_control, o_range_select, o_self_test_plus, o_self_test_minus,
       o_axis_enable} == $past(i_reg_wdata, 2)) else $error("ctl1");
   iface_copy_a: assert property (i_reg_wr && i_reg_addr == 7'h21 |-> ##2
      {o_wire_mode_select, 2'b00, o_filtered_output_select, o_filter_to_detector_two, o_filter_to_detector_one,
       o_cutoff_select} == ($past(i_reg_wdata, 2) & 8'h9f)) else $error("ctl2");
   cutoff_map_a: assert property ($stable(o_sample_rate_select) && $stable(o_cutoff_select) |->
      o_cutoff_quarter_hz == ((o_sample_rate_select ? 6'h20 : 6'h08) >> o_cutoff_select)) else $error("cut");
   pad_one_a: assert property ({o_irq_pad_one, o_irq_pad_one_oe} == $past(want_one))
      else $error("pad1");
   pad_two_a: assert property ({o_irq_pad_two, o_irq_pad_two_oe} == $past(want_two))
      else $error("pad2");
   boot_done_a: assert property ($fell(i_rst) |-> o_boot_busy ##[1:12] !o_boot_busy) else $error("boot");
   reload_busy_a: assert property (i_reg_wr && i_reg_addr == 7'h21 && i_reg_wdata[6] |->
      ##2 o_boot_busy ##[1:12] !o_boot_busy) else $error("reload");
   trim_loaded_a: assert property ($fell(o_boot_busy) |-> o_trim == TRIM_INIT) else $error("trim");
   drdy_gate_a: assert property (o_axis_data_ready != 3'h0 |->
      o_sample_tick && (o_axis_data_ready & ~o_axis_enable) == 3'h0) else $error("drdy");

   cover property (o_filter_clear);
   cover property (o_axis_data_ready != 3'h0);
   cover property ($fell(o_boot_busy));
endmodule
bind acr_regs acr_regs_properties #(.PART_ID(PART_ID), .TRIM_WORDS(TRIM_WORDS), .TRIM_INIT(TRIM_INIT)) u_props (.*);
`default_nettype wire

// [tb/acr_host.sv]
`timescale 1ns/1ps
`default_nettype none
module acr_host
(
   // Clock and read data
   input  wire logic       i_clk,
   input  wire logic [7:0] i_rdata,
   // Register requests
   output var  logic [6:0] o_addr,
   output var  logic       o_wr,
   output var  logic [7:0] o_wdata,
   output var  logic       o_rd
);
   initial
   begin
      o_addr  = 7'h00;
      o_wr    = 1'b0;
      o_wdata = 8'h00;
      o_rd    = 1'b0;
   end

   function automatic logic reserved(input logic [6:0] a);
      return a inside {[7'h00:7'h0e], [7'h10:7'h1f], [7'h24:7'h26], [7'h2e:7'h2f]};
   endfunction

   // Idle lines show the inverse so stale data never looks valid
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      if (!reserved(a))
      begin
         @(posedge i_clk);
         o_addr  <= a;
         o_wdata <= (a == 7'h21) ? d & 8'hdf : d;
         o_wr    <= 1'b1;
         @(posedge i_clk);
         o_wr    <= 1'b0;
         o_addr  <= ~a;
         o_wdata <= ~d;
      end
   endtask

   task automatic rd(input logic [6:0] a, output logic [7:0] d);
      @(posedge i_clk);
      o_addr <= a;
      o_rd   <= 1'b1;
      @(posedge i_clk);
      o_rd   <= 1'b0;
      o_addr <= ~a;
      @(posedge i_clk);
      d = i_rdata;
   endtask
endmodule
`default_nettype wire

// [tb/accel_control_registers_bench.sv]
`timescale 1ns/1ps
`default_nettype none
module accel_control_registers_bench
   import acr_pkg::*;
;
   localparam logic [7:0]  ID   = 8'h5e; // Arbitrary value
   localparam logic [31:0] TRIM = 32'h1234_abcd;
   localparam int          SD   = 40;
   localparam int          FD   = 10;
   localparam logic [7:0]  CTL [4] = '{8'hc7, 8'h38, 8'h45, 8'h82};

   logic i_clk, i_rst, i_reg_wr, i_reg_rd, o_reg_rvalid, o_sample_tick, o_filter_clear, o_boot_busy;
   logic o_sample_rate_select, o_active_mode_control, o_range_select, o_self_test_plus, o_self_test_minus;
   logic o_wire_mode_select, o_filtered_output_select, o_filter_to_detector_one, o_filter_to_detector_two;
   logic i_motion_detector_one, i_motion_detector_two, i_data_ready, i_click;
   logic o_irq_pad_one, o_irq_pad_one_oe, o_irq_pad_two, o_irq_pad_two_oe;
   logic [6:0]  i_reg_addr;
   logic [7:0]  i_reg_wdata, o_reg_rdata, rd_data, d;
   logic [2:0]  o_axis_enable, o_axis_data_ready, code;
   logic [1:0]  o_cutoff_select;
   logic [5:0]  o_cutoff_quarter_hz;
   logic [31:0] o_trim;
   logic [3:0]  srcs;
   int          num_errors = 0;
   int          cmp_count = 0;
   int          clr_seen = 0;
   int          rv_seen = 0;

   // Pulse counters for the one-cycle strobes
   always @(posedge i_clk)
   begin
      clr_seen <= clr_seen + int'(o_filter_clear);
      rv_seen  <= rv_seen + int'(o_reg_rvalid);
   end

   acr_regs #(.PART_ID(ID), .SLOW_DIV(SD), .FAST_DIV(FD), .TRIM_INIT(TRIM)) uut (.*);
   acr_host host (.i_clk(i_clk), .i_rdata(o_reg_rdata), .o_addr(i_reg_addr), .o_wr(i_reg_wr),
                  .o_wdata(i_reg_wdata), .o_rd(i_reg_rd));

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic close_out();
      $display("Comparisons %0d, mismatches %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   task automatic rd_chk(input logic [6:0] a, input logic [7:0] exp);
      host.rd(a, rd_data);
      check(rd_data, exp);
   endtask

   task automatic wait_boot();
      int k;
      k = 0;
      do
      begin
         @(posedge i_clk);
         k++;
      end
      while (o_boot_busy !== 1'b0 && k < 40);
      check(o_boot_busy, 1'b0);
      check(o_trim, TRIM);
   endtask

   // Skips one partial period and one whole one, then measures the next whole one
   task automatic tick_gap(input int exp, input logic [2:0] axes);
      int k;
      for (int j = 0; j < 3; j++)
      begin
         k = 0;
         do
         begin
            @(posedge i_clk);
            k++;
         end
         while (o_sample_tick !== 1'b1 && k < 500);
      end
      check(k, exp);
      check(o_axis_data_ready, axes);
   endtask

   function automatic logic [1:0] pad(input logic [2:0] c, input logic pol, input logic od);
      logic l;
      l = pol ^ (c == 3'h1 ? srcs[0] : c == 3'h2 ? srcs[1] : c == 3'h3 ? |srcs[1:0] :
                 c == 3'h4 ? srcs[2] : c == 3'h7 ? srcs[3] : 1'b0);
      return od ? {1'b0, ~l} : {l, 1'b1};
   endfunction

   initial
   begin
      i_clk = 1'b0;
      forever #12.5 i_clk = ~i_clk;
   end

   // About thirty times the expected length of the run
   initial
   begin
      repeat (20000) @(posedge i_clk);
      num_errors++;
      close_out();
   end

   initial
   begin
      i_rst = 1'b1;
      srcs = 4'h0;
      {i_click, i_data_ready, i_motion_detector_two, i_motion_detector_one} = 4'h0;
      repeat (4) @(posedge i_clk);
      i_rst <= 1'b0;
      check(o_boot_busy, 1'b1);
      wait_boot();
      rd_chk(7'h20, 8'h07);
      rd_chk(7'h21, 8'h00);
      rd_chk(7'h22, 8'h00);
      check({o_irq_pad_one_oe, o_irq_pad_two_oe, o_cutoff_quarter_hz}, 8'hc8);
      host.wr(7'h0f, 8'h00);
      rd_chk(7'h0f, ID);
      rd_chk(7'h10, 8'h00);
      host.wr(7'h23, 8'hff);
      rd_chk(7'h23, 8'h00);
      rd_chk(7'h20, 8'h07);
      @(posedge i_clk);
      check(rv_seen, 7);
      check(clr_seen, 1);
      foreach (CTL[i])
      begin
         host.wr(7'h20, CTL[i]);
         rd_chk(7'h20, CTL[i]);
         check({o_sample_rate_select, o_active_mode_control, o_range_select, o_self_test_plus,
                o_self_test_minus, o_axis_enable}, CTL[i]);
      end
      host.wr(7'h20, 8'h45);
      tick_gap(SD, 3'h5);
      host.wr(7'h20, 8'hc3);
      tick_gap(FD, 3'h3);
      host.wr(7'h20, 8'h87);
      code = 3'h0;
      repeat (60)
      begin
         @(posedge i_clk);
         if (o_sample_tick !== 1'b0)
            code = code + 3'h1;
      end
      check(code, 3'h0);
      for (int i = 0; i < 8; i++)
      begin
         d = {i[2], 2'b00, i[0], i[1], ~i[1], i[1:0]};
         host.wr(7'h20, {i[2], 7'h07});
         host.wr(7'h21, d);
         rd_chk(7'h21, d);
         check({o_wire_mode_select, o_filtered_output_select, o_filter_to_detector_two,
                o_filter_to_detector_one, o_cutoff_select}, {d[7], d[4:0]});
         check(o_cutoff_quarter_hz, (i[2] ? 6'h20 : 6'h08) >> i[1:0]);
      end
      host.wr(7'h21, 8'h40);
      rd_chk(7'h21, 8'h40);
      wait_boot();
      rd_chk(7'h21, 8'h00);
      for (int i = 0; i < 64; i++)
      begin
         code = i[2:0];
         srcs = i[5] ? 4'ha : 4'h5;
         {i_click, i_data_ready, i_motion_detector_two, i_motion_detector_one} <= srcs;
         host.wr(7'h22, {i[3], i[4], code + 3'h1, code});
         repeat (3) @(posedge i_clk);
         check({o_irq_pad_one, o_irq_pad_one_oe, o_irq_pad_two, o_irq_pad_two_oe},
               {pad(code, i[3], i[4]), pad(code + 3'h1, i[3], i[4])});
      end
      i_rst <= 1'b1;
      repeat (4) @(posedge i_clk);
      i_rst <= 1'b0;
      wait_boot();
      rd_chk(7'h22, 8'h00);
      rd_chk(7'h20, 8'h07);
      close_out();
   end
endmodule
`default_nettype wire
